// File: logic/cla_pkg.sv
// package: constants and types shared by the control location arbiter
`default_nettype none

package cla_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int unsigned CLA_SET_W  = 16;
   localparam int unsigned CLA_WD_W   = 32;
   localparam int unsigned CLA_STAT_W = 8;
   localparam int unsigned CLA_SYNC_N = 3;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [CLA_SET_W-1:0]  CLA_SET_RST  = 16'h0000;
   localparam logic [CLA_WD_W-1:0]   CLA_WD_RST   = 32'h0000_0000;
   localparam logic [CLA_SYNC_N-1:0] CLA_REM_RST  = 3'h7;
   localparam logic [CLA_SYNC_N-1:0] CLA_SB_RST   = 3'h0;

   // ----------------------------------------------------------------
   // status word field positions
   // ----------------------------------------------------------------
   localparam int unsigned CLA_ST_LOC_LSB  = 0;
   localparam int unsigned CLA_ST_OUT      = 2;
   localparam int unsigned CLA_ST_LOCAL    = 3;
   localparam int unsigned CLA_ST_SB       = 4;
   localparam int unsigned CLA_ST_MODE_LSB = 5;
   localparam int unsigned CLA_ST_ALARM    = 7;

   // ----------------------------------------------------------------
   // enumerations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CLA_LOC_MANUAL  = 2'b00,
      CLA_LOC_ANALOG  = 2'b01,
      CLA_LOC_DIGITAL = 2'b10,
      CLA_LOC_LOCAL   = 2'b11
   } cla_loc_t;

   typedef enum logic [1:0] {
      CLA_SEL_U = 2'b00,
      CLA_SEL_I = 2'b01,
      CLA_SEL_P = 2'b10
   } cla_sel_t;

endpackage : cla_pkg

`default_nettype wire

// File: logic/cla_wdog.sv
// communication watchdog for the digital remote interface
`default_nettype none

module cla_wdog
   import cla_pkg::*;
(
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                arst_n,
   input  wire logic                clk_en,
   // control
   input  wire logic                active,
   input  wire logic                msg_rx,
   input  wire logic [CLA_WD_W-1:0] timeout,
   // event
   output logic                     expire
);

   typedef struct packed {
      logic [CLA_WD_W-1:0] cnt;
      logic [CLA_WD_W-1:0] tc;
      logic                exp;
   } cla_wd_state_t;

   cla_wd_state_t st_ff;
   cla_wd_state_t nxt_st;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st     = st_ff;
      nxt_st.exp = 1'b0;
      if (!active) begin
         // idle: hold cleared and let a new timeout load freely
         nxt_st.cnt = CLA_WD_RST;
         nxt_st.tc  = timeout;
      end else if (msg_rx) begin
         nxt_st.cnt = CLA_WD_RST;                              // [RULE12]
      end else if ((s_next_cnt(st_ff.cnt)) >= st_ff.tc) begin
         nxt_st.exp = 1'b1;                                    // [RULE22]
         nxt_st.cnt = CLA_WD_RST;
         // a changed timeout is only picked up once a period has run out
         nxt_st.tc  = timeout;                                 // [RULE20]
      end else begin
         nxt_st.cnt = s_next_cnt(st_ff.cnt);                   // [RULE22]
      end
   end

   function automatic logic [CLA_WD_W-1:0] s_next_cnt(input logic [CLA_WD_W-1:0] c);
      s_next_cnt = c + 1'b1;
   endfunction : s_next_cnt

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '{cnt: CLA_WD_RST, tc: CLA_WD_RST, exp: 1'b0};
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   assign expire = st_ff.exp;

endmodule : cla_wdog

`default_nettype wire

// File: logic/cla_arbiter.sv
// control location arbiter: owner of control, output switching, watchdog use
//
// Operation
// [RULE1] only one remote port, analog or digital, holds control at a time
// [RULE2] digital remote request during analog remote is refused with an error
// [RULE3] during digital remote, the analog takeover pin is ignored
// [RULE4] status queries and readback are served in every control location
// [RULE5] manual control accepts takeover from both analog and digital sides
// [RULE6] local lock refuses all remote control, front panel only
// [RULE7] remote-inhibit setting forces local lock and shows it
// [RULE8] local lock ends digital remote at once; host must request again
// [RULE9] local lock suspends analog remote; it resumes if pin still asserts
// [RULE10] entering remote keeps current voltage, current and power set values; analog remote instead loads them from the analog pins each cycle
// [RULE11] watchdog runs only while digital remote control is active
// [RULE12] every received message restarts the watchdog
// [RULE13] watchdog expiry leaves remote and returns to manual control
// [RULE14] on expiry output goes off or stays on per configuration
// [RULE15] panel button toggles output unless alarm blocks or remote is active
// [RULE16] green indicator for output on, red for output off
// [RULE17] locked panel blocks manual switching and prompts for unlock
// [RULE18] standby inhibit pin may block enabling output, with a notice
// [RULE19] active regulation mode is always shown in the alternative layout
// [RULE20] new watchdog timeout applies only after the running period ends
// [RULE21] watchdog enable may change at any time
// [RULE22] watchdog counts clock ticks to a terminal count, one-cycle expiry
`default_nettype none

module cla_arbiter
   import cla_pkg::*;
(
   // clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  arst_n,
   input  wire logic                  clk_en,
   // analog interface pins
   input  wire logic                  ana_takeover_n,
   input  wire logic                  standby_inhibit_pin,
   input  wire logic [CLA_SET_W-1:0]  ana_set_u,
   input  wire logic [CLA_SET_W-1:0]  ana_set_i,
   input  wire logic [CLA_SET_W-1:0]  ana_set_p,
   // digital interface requests
   input  wire logic                  dig_msg_rx,
   input  wire logic                  dig_remote_req,
   input  wire logic                  dig_remote_exit,
   input  wire logic                  dig_out_on,
   input  wire logic                  dig_out_off,
   input  wire logic                  dig_set_wr,
   input  wire logic                  dig_query,
   // front panel
   input  wire logic                  front_panel_onoff,
   input  wire logic                  front_panel_locked,
   input  wire logic                  front_panel_set_wr,
   // shared set value write data
   input  wire logic [1:0]            set_sel,
   input  wire logic [CLA_SET_W-1:0]  set_data,
   // configuration
   input  wire logic                  cfg_allow_remote,
   input  wire logic                  cfg_keep_out_after_remote,
   input  wire logic                  cfg_sb_inhibit_en,
   input  wire logic                  cfg_wdog_en,
   input  wire logic [CLA_WD_W-1:0]   cfg_wdog_timeout,
   // device condition
   input  wire logic                  alarm_block,
   input  wire logic [1:0]            reg_mode,
   // control location and errors
   output logic [1:0]                 ctrl_loc,
   output logic                       local_shown,
   output logic                       dig_err,
   output logic                       wdog_expired,
   // readback
   output logic                       dig_ack,
   output logic [CLA_STAT_W-1:0]      dig_status,
   output logic [CLA_STAT_W-1:0]      ana_status,
   // output stage and indicators
   output logic                       output_on,
   output logic                       led_green,
   output logic                       led_red,
   output logic                       unlock_prompt,
   output logic                       sb_notice,
   output logic [1:0]                 reg_mode_shown,
   // active set values
   output logic [CLA_SET_W-1:0]       set_u,
   output logic [CLA_SET_W-1:0]       set_i,
   output logic [CLA_SET_W-1:0]       set_p
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [CLA_SYNC_N-1:0] rem_sync;
      logic                  rem_lvl;
      logic [CLA_SYNC_N-1:0] sb_sync;
      logic                  sb_lvl;
      cla_loc_t              loc;
      logic                  out_on;
      logic [CLA_SET_W-1:0]  set_u;
      logic [CLA_SET_W-1:0]  set_i;
      logic [CLA_SET_W-1:0]  set_p;
      logic                  dig_err;
      logic                  dig_ack;
      logic [CLA_STAT_W-1:0] dig_status;
      logic [CLA_STAT_W-1:0] ana_status;
      logic                  unlock_prompt;
      logic                  sb_notice;
      logic                  wd_exp;
      logic                  led_green;
      logic                  led_red;
      logic [1:0]            mode_shown;
      logic                  loc_shown;
   } cla_state_t;

   cla_state_t st_ff;
   cla_state_t nxt_st;

   logic wd_active;
   logic wd_expire;
   logic analog_wants;
   logic sb_blocks;
   logic on_req;
   logic off_req;
   logic set_wr;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // a synchronised pin level moves only once the last two stages agree
   function automatic logic s_filter(input logic [CLA_SYNC_N-1:0] s, input logic cur);
      s_filter = (s[2] == s[1]) ? s[2] : cur;
   endfunction : s_filter

   // one set value takes the write data when it is the selected one
   function automatic logic [CLA_SET_W-1:0] s_set_upd(
      input logic [CLA_SET_W-1:0] cur,
      input logic                 wr,
      input logic [1:0]           sel,
      input cla_sel_t             mine,
      input logic [CLA_SET_W-1:0] data);
      s_set_upd = (wr && (sel == mine)) ? data : cur;
   endfunction : s_set_upd

   function automatic logic [CLA_STAT_W-1:0] s_status(
      input cla_loc_t   loc,
      input logic       out_on,
      input logic       sb,
      input logic [1:0] mode,
      input logic       alarm);
      logic [CLA_STAT_W-1:0] w;
      w = '0;
      w[CLA_ST_LOC_LSB +: 2]  = loc;
      w[CLA_ST_OUT]           = out_on;
      w[CLA_ST_LOCAL]         = (loc == CLA_LOC_LOCAL);
      w[CLA_ST_SB]            = sb;
      w[CLA_ST_MODE_LSB +: 2] = mode;
      w[CLA_ST_ALARM]         = alarm;
      s_status = w;
   endfunction : s_status

   // ----------------------------------------------------------------
   // watchdog
   // ----------------------------------------------------------------
   // enable is sampled live, so software may flip it at any moment
   assign wd_active = (st_ff.loc == CLA_LOC_DIGITAL) && cfg_wdog_en;   // [RULE11] [RULE21]

   cla_wdog u_wdog (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .clk_en  (clk_en),
      .active  (wd_active),
      .msg_rx  (dig_msg_rx),          // [RULE12]
      .timeout (cfg_wdog_timeout),
      .expire  (wd_expire)
   );

   // ----------------------------------------------------------------
   // decoded conditions
   // ----------------------------------------------------------------
   assign analog_wants = st_ff.rem_lvl == 1'b0;
   // standby inhibit acts in manual, digital remote and local lock operation, not in analog remote
   assign sb_blocks = cfg_sb_inhibit_en && st_ff.sb_lvl &&
                      (st_ff.loc != CLA_LOC_ANALOG);                   // [RULE18]
   assign on_req  = dig_out_on  && (st_ff.loc == CLA_LOC_DIGITAL);
   assign off_req = dig_out_off && (st_ff.loc == CLA_LOC_DIGITAL);
   assign set_wr  = (front_panel_set_wr && (st_ff.loc[1] == st_ff.loc[0])) ||
                    (dig_set_wr && (st_ff.loc == CLA_LOC_DIGITAL));

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st               = st_ff;
      nxt_st.dig_err       = 1'b0;
      nxt_st.dig_ack       = 1'b0;
      nxt_st.unlock_prompt = 1'b0;
      nxt_st.wd_exp        = wd_expire && (st_ff.loc == CLA_LOC_DIGITAL);

      // pin synchronisers; stage 0 feeds only stage 1
      nxt_st.rem_sync = {st_ff.rem_sync[1:0], ana_takeover_n};
      nxt_st.sb_sync  = {st_ff.sb_sync[1:0], standby_inhibit_pin};
      nxt_st.rem_lvl  = s_filter(st_ff.rem_sync, st_ff.rem_lvl);
      nxt_st.sb_lvl   = s_filter(st_ff.sb_sync, st_ff.sb_lvl);

      // control location
      unique case (st_ff.loc)
         CLA_LOC_MANUAL: begin
            if (!cfg_allow_remote) begin
               nxt_st.loc = CLA_LOC_LOCAL;                            // [RULE7]
               if (dig_remote_req) begin
                  nxt_st.dig_err = 1'b1;                              // [RULE6]
               end
            end else if (analog_wants) begin
               // analog has the pin level already; a digital bid loses
               nxt_st.loc = CLA_LOC_ANALOG;                           // [RULE5] [RULE1]
               if (dig_remote_req) begin
                  nxt_st.dig_err = 1'b1;                              // [RULE2]
               end
            end else if (dig_remote_req) begin
               nxt_st.loc = CLA_LOC_DIGITAL;                          // [RULE5]
            end
         end
         CLA_LOC_ANALOG: begin
            if (dig_remote_req) begin
               nxt_st.dig_err = 1'b1;                                 // [RULE2] [RULE1]
            end
            if (!cfg_allow_remote) begin
               nxt_st.loc = CLA_LOC_LOCAL;                            // [RULE9]
            end else if (!analog_wants) begin
               nxt_st.loc = CLA_LOC_MANUAL;
            end
         end
         CLA_LOC_DIGITAL: begin
            // the analog pin is not looked at here at all
            if (!cfg_allow_remote) begin
               nxt_st.loc = CLA_LOC_LOCAL;                            // [RULE8] [RULE3]
            end else if (wd_expire || dig_remote_exit) begin
               nxt_st.loc = CLA_LOC_MANUAL;                           // [RULE13]
            end
         end
         CLA_LOC_LOCAL: begin
            if (dig_remote_req) begin
               nxt_st.dig_err = 1'b1;                                 // [RULE6]
            end
            // a suspended analog session resumes straight away on release
            if (cfg_allow_remote) begin
               nxt_st.loc = analog_wants ? CLA_LOC_ANALOG : CLA_LOC_MANUAL;  // [RULE9]
            end
         end
      endcase

      // digital output and set value commands outside digital remote are refused
      if ((dig_out_on || dig_out_off || dig_set_wr) && (st_ff.loc != CLA_LOC_DIGITAL)) begin
         nxt_st.dig_err = 1'b1;                                       // [RULE6]
      end

      // set values: analog remote loads them from the analog pins each cycle; elsewhere nothing is reloaded on a change of owner
      if (st_ff.loc == CLA_LOC_ANALOG) begin
         nxt_st.set_u = ana_set_u;
         nxt_st.set_i = ana_set_i;
         nxt_st.set_p = ana_set_p;
      end else begin
         nxt_st.set_u = s_set_upd(st_ff.set_u, set_wr,
                                  set_sel, CLA_SEL_U, set_data);      // [RULE10]
         nxt_st.set_i = s_set_upd(st_ff.set_i, set_wr,
                                  set_sel, CLA_SEL_I, set_data);      // [RULE10]
         nxt_st.set_p = s_set_upd(st_ff.set_p, set_wr,
                                  set_sel, CLA_SEL_P, set_data);      // [RULE10]
      end

      // output switching
      if (st_ff.loc == CLA_LOC_ANALOG) begin
         // under analog remote the standby pin itself drives on and off
         nxt_st.out_on = !st_ff.sb_lvl && !alarm_block;
      end else if ((st_ff.loc == CLA_LOC_DIGITAL) && wd_expire) begin
         if (!cfg_keep_out_after_remote) begin
            nxt_st.out_on = 1'b0;                                     // [RULE14]
         end
      end else if (on_req && !alarm_block && !sb_blocks) begin
         nxt_st.out_on = 1'b1;                                        // [RULE18]
      end else if (off_req) begin
         nxt_st.out_on = 1'b0;
      end else if (front_panel_onoff) begin
         if (front_panel_locked) begin
            nxt_st.unlock_prompt = 1'b1;                              // [RULE17]
         end else if (!alarm_block && (st_ff.loc[1] == st_ff.loc[0])) begin
            // manual or local only; turning on may still be inhibited
            if (st_ff.out_on) begin
               nxt_st.out_on = 1'b0;                                  // [RULE15]
            end else if (!sb_blocks) begin
               nxt_st.out_on = 1'b1;                                  // [RULE15] [RULE18]
            end
         end
      end

      // notice is a level so the display can hold it while the pin blocks
      nxt_st.sb_notice = sb_blocks;                                   // [RULE18]

      // indicators take the next output state, so they change on the same edge as the output
      nxt_st.led_green = nxt_st.out_on;                               // [RULE16]
      nxt_st.led_red   = !nxt_st.out_on;                              // [RULE16]

      // mode is shown regardless of which pair of values is on screen
      nxt_st.mode_shown = reg_mode;                                   // [RULE19]
      nxt_st.loc_shown  = (nxt_st.loc == CLA_LOC_LOCAL);              // [RULE7]

      // readback keeps running whoever owns control
      nxt_st.ana_status = s_status(st_ff.loc, st_ff.out_on, sb_blocks, reg_mode,
                                   alarm_block);                      // [RULE4]
      if (dig_query) begin
         nxt_st.dig_ack    = 1'b1;                                    // [RULE4]
         nxt_st.dig_status = s_status(st_ff.loc, st_ff.out_on, sb_blocks, reg_mode,
                                      alarm_block);
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '{rem_sync:      CLA_REM_RST,
                    rem_lvl:       1'b1,
                    sb_sync:       CLA_SB_RST,
                    sb_lvl:        1'b0,
                    loc:           CLA_LOC_MANUAL,
                    out_on:        1'b0,
                    set_u:         CLA_SET_RST,
                    set_i:         CLA_SET_RST,
                    set_p:         CLA_SET_RST,
                    dig_err:       1'b0,
                    dig_ack:       1'b0,
                    dig_status:    '0,
                    ana_status:    '0,
                    unlock_prompt: 1'b0,
                    sb_notice:     1'b0,
                    wd_exp:        1'b0,
                    led_green:     1'b0,
                    led_red:       1'b1,
                    mode_shown:    2'h0,
                    loc_shown:     1'b0};
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign ctrl_loc       = st_ff.loc;
   assign local_shown    = st_ff.loc_shown;                            // [RULE7]
   assign dig_err        = st_ff.dig_err;
   assign wdog_expired   = st_ff.wd_exp;
   assign dig_ack        = st_ff.dig_ack;
   assign dig_status     = st_ff.dig_status;
   assign ana_status     = st_ff.ana_status;
   assign output_on      = st_ff.out_on;
   assign led_green      = st_ff.led_green;
   assign led_red        = st_ff.led_red;
   assign unlock_prompt  = st_ff.unlock_prompt;
   assign sb_notice      = st_ff.sb_notice;
   assign reg_mode_shown = st_ff.mode_shown;
   assign set_u          = st_ff.set_u;
   assign set_i          = st_ff.set_i;
   assign set_p          = st_ff.set_p;

endmodule : cla_arbiter

`default_nettype wire

// File: test/cla_arbiter_properties.sv
// checker: port-level properties of the control location arbiter
`default_nettype none
module cla_arbiter_properties
   import cla_pkg::*;
(
   // clock and reset
   input wire logic       sys_clk, arst_n,
   // requests and settings
   input wire logic       dig_remote_req, dig_query, front_panel_onoff, front_panel_locked,
   input wire logic       cfg_allow_remote, cfg_keep_out_after_remote,
   // observed outputs
   input wire logic [1:0] ctrl_loc,
   input wire logic       local_shown, dig_err, wdog_expired, dig_ack,
   input wire logic       output_on, led_green, led_red, unlock_prompt
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   lock_entry_a: assert property (!cfg_allow_remote |=> ctrl_loc == 2'h3)
      else $error("lock not entered");
   lock_shown_a: assert property (local_shown == (ctrl_loc == 2'h3))
      else $error("lock display wrong");
   analog_refuse_a: assert property (ctrl_loc == 2'h1 && dig_remote_req
      |=> dig_err && ctrl_loc != 2'h2)
      else $error("digital request not refused");
   pin_ignored_a: assert property (ctrl_loc == 2'h2 && cfg_allow_remote
      |=> ctrl_loc != 2'h1)
      else $error("pin took over from digital");
   expiry_manual_a: assert property (wdog_expired && $past(cfg_allow_remote)
      |-> $past(ctrl_loc) == 2'h2 && ctrl_loc == 2'h0)
      else $error("expiry outside digital or not to manual");
   expiry_out_a: assert property (wdog_expired && !$past(cfg_keep_out_after_remote)
      |-> !output_on)
      else $error("output left on at expiry");
   led_pair_a: assert property (led_green == output_on && led_red != output_on)
      else $error("indicators disagree with output");
   locked_hold_a: assert property (ctrl_loc == 2'h0 && front_panel_locked
      |=> $stable(output_on))
      else $error("locked panel switched output");
   unlock_ask_a: assert property (ctrl_loc == 2'h0 && front_panel_onoff && front_panel_locked
      |=> unlock_prompt)
      else $error("no unlock prompt");
   query_ack_a: assert property (dig_query |=> dig_ack)
      else $error("query not answered");
endmodule : cla_arbiter_properties
`default_nettype wire

// File: test/cla_host_model.sv
// host model: digital-side message source for the arbiter bench
`default_nettype none
module cla_host_model #(
   parameter int PERIOD = 4
) (
   // clock
   input  wire logic sys_clk,
   // control from the bench
   input  wire logic beat_en,
   // message strobe towards the arbiter
   output var logic  dig_msg_rx
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   initial dig_msg_rx = 1'b0;
   // beat period stays below the timeout
   always @(negedge sys_clk) begin
      cnt = beat_en ? (cnt + 1) % PERIOD : 0;
      dig_msg_rx <= beat_en && cnt == 0;
   end
endmodule : cla_host_model
`default_nettype wire

// File: test/cla_arbiter_bench.sv
// testbench: control location arbiter with host model and checker
`default_nettype none
module cla_arbiter_bench
   import cla_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, arst_n, clk_en, ana_takeover_n, standby_inhibit_pin, beat_en;
   logic [CLA_SET_W-1:0] ana_set_u, ana_set_i, ana_set_p, set_data, set_u, set_i, set_p;
   logic dig_msg_rx, dig_remote_req, dig_remote_exit, dig_out_on, dig_out_off, dig_set_wr;
   logic dig_query, front_panel_onoff, front_panel_locked, front_panel_set_wr, alarm_block;
   logic cfg_allow_remote, cfg_keep_out_after_remote, cfg_sb_inhibit_en, cfg_wdog_en;
   logic [1:0] set_sel, reg_mode, ctrl_loc, reg_mode_shown;
   logic [CLA_WD_W-1:0] cfg_wdog_timeout;
   logic [CLA_STAT_W-1:0] dig_status, ana_status;
   logic local_shown, dig_err, wdog_expired, dig_ack, output_on, led_green, led_red;
   logic unlock_prompt, sb_notice;
   int   n_errors = 0;
   int   n_checks = 0;
   cla_arbiter dut (.*);
   cla_host_model #(.PERIOD(4)) host (.*);
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask : check
   task automatic summarize;
      if (n_errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize
   task automatic tick(input int n = 1);
      repeat (n) @(negedge sys_clk);
   endtask : tick
   // a pulse spans exactly one rising edge
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick();
      s = 1'b0;
   endtask : pulse
   task automatic wait_loc(input logic [1:0] loc);
      for (int k = 0; k < 40 && ctrl_loc !== loc; k++) tick();
      check(ctrl_loc, loc, "location");
      if (ctrl_loc !== loc) summarize();
   endtask : wait_loc
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic panel_s;
      pulse(front_panel_onoff); check(output_on, 1, "panel on");
      check({led_green, led_red}, 2'b10, "leds on");
      alarm_block = 1'b1; pulse(front_panel_onoff); check(output_on, 1, "alarm");
      alarm_block = 1'b0; front_panel_locked = 1'b1; pulse(front_panel_onoff);
      check(unlock_prompt, 1, "prompt");
      check(output_on, 1, "locked");
      front_panel_locked = 1'b0; pulse(front_panel_onoff);
      check({led_green, led_red}, 2'b01, "leds off");
      standby_inhibit_pin = 1'b1; cfg_sb_inhibit_en = 1'b1; tick(4); pulse(front_panel_onoff);
      check({sb_notice, output_on}, 2'b10, "inhibit"); standby_inhibit_pin = 1'b0;
      set_sel = 2'h2; set_data = 16'h1234; pulse(front_panel_set_wr);
      pulse(dig_out_off); check(dig_err, 1, "refused off");
      reg_mode = 2'h2; tick(2); check(reg_mode_shown, 2'h2, "mode");
   endtask : panel_s
   task automatic lock_digital_s;
      pulse(dig_remote_req); check(ctrl_loc, 2'h2, "digital");
      cfg_allow_remote = 1'b0; tick(2); check(local_shown, 1, "local");
      cfg_allow_remote = 1'b1; tick(3); check(ctrl_loc, 2'h0, "not resumed");
      pulse(dig_remote_req); pulse(dig_remote_exit); check(ctrl_loc, 2'h0, "exit");
   endtask : lock_digital_s
   task automatic digital_s;
      beat_en = 1'b1; cfg_keep_out_after_remote = 1'b0;
      pulse(dig_remote_req); check(set_p, 16'h1234, "kept");
      pulse(dig_out_on); ana_takeover_n = 1'b0;
      pulse(dig_query); check({dig_ack, dig_status}, 9'h146, "query");
      tick(30); check(ctrl_loc, 2'h2, "pin ignored");
      cfg_wdog_en = 1'b1; tick(30); check(ctrl_loc, 2'h2, "beats");
      beat_en = 1'b0; wait_loc(2'h0);
      check(output_on, 0, "off at expiry");
   endtask : digital_s
   task automatic analog_s;
      ana_set_u = 16'h0bcd; ana_set_i = 16'h0bcd; ana_set_p = 16'h0bcd;
      wait_loc(2'h1);
      pulse(dig_remote_req); check({dig_err, ctrl_loc}, 3'h5, "refuse");
      check(set_p, 16'h0bcd, "analog set");
      cfg_allow_remote = 1'b0; tick(); pulse(dig_remote_req);
      check({dig_err, ctrl_loc}, 3'h7, "lock refuse");
      cfg_allow_remote = 1'b1; tick(2); check({ana_status, ctrl_loc}, 10'h115, "resume");
      ana_takeover_n = 1'b1; wait_loc(2'h0);
   endtask : analog_s
   initial begin
      {dig_remote_req, dig_remote_exit, dig_out_on, dig_out_off, dig_set_wr, dig_query} = '0;
      {front_panel_onoff, front_panel_locked, front_panel_set_wr, alarm_block, beat_en} = '0;
      {standby_inhibit_pin, cfg_sb_inhibit_en, cfg_wdog_en, set_sel, reg_mode} = '0;
      {ana_set_u, ana_set_i, ana_set_p, set_data} = '0;
      clk_en = 1'b1; ana_takeover_n = 1'b1; cfg_allow_remote = 1'b1;
      cfg_keep_out_after_remote = 1'b1; cfg_wdog_timeout = 32'h0000_0008;
      arst_n = 1'b0;
      tick(12);
      arst_n = 1'b1;
      tick();
      panel_s();
      lock_digital_s();
      digital_s();
      analog_s();
      summarize();
   end
endmodule : cla_arbiter_bench
bind cla_arbiter cla_arbiter_properties chk (.*);
`default_nettype wire
